//--- hw/dcvc_top.sv
// Purpose: debug control, status, vector catch, single-step, watchpoint coupling
// Assumes: all inputs synchronous to clk_i; wishbone classic slave
// Notes:
// Operation
// - debug ack or inhibit blocks both interrupts
// - synced request bit ORed with external request
// - outgoing ack is core ack OR bit0
// - five-bit read-only status register
// - status bits 1:0 synced external request and ack
// - status bit 2 core interrupt enable
// - status bit 3 system access done
// - status bit 4 compressed state flag
// - eight-bit vector catch, bit 5 reserved
// - caught exception enters debug like breakpoint
// - caught vector fetch raises instruction breakpoint
// - only exception entry fetches are caught
// - monitor mode ignores abort vector catch
// - step bit: one instruction per debug exit
// - chain: unit 0 needs earlier unit 1 match
// - range: unit 0 uses unit 1 address hit
// - address input: instruction or data address bus
// - data input: instruction, read or write data
// - nine-bit value, eight-bit mask, ten-bit bus
// - six-bit debug control register layout
// - debug disable forces breaks low, interrupts free
// - external debug inputs sampled on rising edge
//
// Design decisions made here: the Wishbone interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "dcvc_cfg.svh"
module dcvc_top #(
    parameter int NUM_WP = 2
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone classic slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    // system side
    input  wire logic        debug_enable_pin_i,
    input  wire logic        external_debug_request_i,
    input  wire logic [1:0]  external_debug_inputs_i,
    output logic             debug_acknowledge_o,
    input  wire logic        irq_i,
    input  wire logic        fiq_i,
    // core side
    output logic             irq_o,
    output logic             fiq_o,
    output logic             debug_request_o,
    input  wire logic        core_debug_acknowledge_i,
    input  wire logic        core_interrupt_enable_i,
    input  wire logic        system_access_done_i,
    input  wire logic        compressed_state_flag_i,
    input  wire logic        fetch_valid_i,
    input  wire logic        exception_entry_fetch_i,
    input  wire logic        data_access_valid_i,
    input  wire logic        data_write_i,
    input  wire logic [5:0]  core_ctrl_i,
    input  wire logic [31:0] instruction_address_bus_i,
    input  wire logic [31:0] data_address_bus_i,
    input  wire logic [31:0] fetched_instruction_bus_i,
    input  wire logic [31:0] read_data_i,
    input  wire logic [31:0] write_data_i,
    output logic             instruction_breakpoint_o,
    output logic             data_watchpoint_o
);
    import dcvc_pkg::*;

    dcvc_state_s       st_r;
    dcvc_state_s       st_nxt;
    logic              req;
    logic              wr;
    logic              ack_comb;
    logic [4:0]        status;
    logic [31:0]       wmask;
    logic [31:0]       rd_val;
    logic [NUM_WP-1:0] addr_hit;
    logic [NUM_WP-1:0] addr_ctl_hit;
    logic [NUM_WP-1:0] data_hit;
    logic [NUM_WP-1:0] trig;
    logic [NUM_WP-1:0] fetched_instruction_bus_trig;
    logic [NUM_WP-1:0] data_trig;
    logic              vc_hit;
    logic              step_break;
    logic [2:0]        vec_idx;

    assign req  = cyc_i & stb_i & ~st_r.ack;
    assign wr   = req & we_i;
    assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

    assign ack_comb = core_debug_acknowledge_i | st_r.ctrl[`DCVC_CTRL_ACK];
    assign debug_acknowledge_o = ack_comb & debug_enable_pin_i;
    assign debug_request_o = (st_r.rq_s2 | external_debug_request_i) & debug_enable_pin_i;
    assign irq_o = irq_i & ~(debug_enable_pin_i & (ack_comb | st_r.ctrl[`DCVC_CTRL_INHIBIT]));
    assign fiq_o = fiq_i & ~(debug_enable_pin_i & (ack_comb | st_r.ctrl[`DCVC_CTRL_INHIBIT]));

    assign status = {compressed_state_flag_i, system_access_done_i, core_interrupt_enable_i,
                     st_r.erq_s2, st_r.dack_s2};

    // watchpoint units
    genvar g;
    generate
        for (g = 0; g < NUM_WP; g++) begin : g_wp
            logic [31:0] abus;
            logic [31:0] dbus;
            logic [9:0]  cbus;
            logic        is_data;
            logic        chain_in;
            logic        range_in;
            assign is_data  = st_r.cv[g][`DCVC_CV_DATA];
            assign abus     = is_data ? data_address_bus_i : instruction_address_bus_i;
            assign dbus     = !is_data ? fetched_instruction_bus_i
                            : (data_write_i ? write_data_i : read_data_i);
            assign chain_in = (g == 0) ? st_r.chain : 1'b0;
            assign range_in = (g == 0 && NUM_WP > 1) ? addr_hit[NUM_WP-1] : 1'b0;
            assign cbus = {(is_data ? data_access_valid_i : fetch_valid_i),
                           ~st_r.ctrl[`DCVC_CTRL_CMPOFF], range_in, chain_in,
                           st_r.ext_q[g % 2], core_ctrl_i[4:0]};
            dcvc_watchpoint u_wp (
                .av_i           (st_r.av[g]),
                .am_i           (st_r.am[g]),
                .dv_i           (st_r.dv[g]),
                .dm_i           (st_r.dm[g]),
                .cv_i           (st_r.cv[g]),
                .cm_i           (st_r.cm[g]),
                .addr_i         (abus),
                .data_i         (dbus),
                .cbus_i         (cbus),
                .addr_hit_o     (addr_hit[g]),
                .addr_ctl_hit_o (addr_ctl_hit[g]),
                .data_hit_o     (data_hit[g]),
                .trigger_o      (trig[g])
            );
            assign fetched_instruction_bus_trig[g] = trig[g] & ~is_data;
            assign data_trig[g]  = trig[g] & is_data;
        end
    endgenerate

    // vector catch on exception entry fetches only
    assign vec_idx = instruction_address_bus_i[4:2];
    always_comb begin
        vc_hit = 1'b0;
        if (fetch_valid_i && exception_entry_fetch_i
            && instruction_address_bus_i[31:5] == 27'h0000000
            && instruction_address_bus_i[1:0] == 2'h0) begin
            vc_hit = st_r.vcatch[vec_idx];
            if (vec_idx == 3'(`DCVC_VC_RSVD)) begin
                vc_hit = 1'b0;
            end
            if (st_r.ctrl[`DCVC_CTRL_MONITOR] && (vec_idx == 3'(`DCVC_VC_PABORT)
                || vec_idx == 3'(`DCVC_VC_DABORT))) begin
                vc_hit = 1'b0;
            end
        end
    end

    // second fetch after debug exit breaks again
    assign step_break = (st_r.step == STEP_SECOND) & fetch_valid_i;

    assign instruction_breakpoint_o = debug_enable_pin_i & (vc_hit | step_break | (|fetched_instruction_bus_trig));
    assign data_watchpoint_o        = debug_enable_pin_i & (|data_trig);

    // register read mux
    always_comb begin
        rd_val = 32'h00000000;
        if (adr_i == `DCVC_ADR_CTRL) begin
            rd_val = {26'h0000000, st_r.ctrl};
        end else if (adr_i == `DCVC_ADR_STATUS) begin
            rd_val = {27'h0000000, status};
        end else if (adr_i == `DCVC_ADR_VCATCH) begin
            rd_val = {24'h000000, st_r.vcatch};
        end else begin
            for (int i = 0; i < NUM_WP; i++) begin
                if (adr_i == 8'(`DCVC_WP_BASE + i * `DCVC_WP_STRIDE + `DCVC_WP_AV)) begin
                    rd_val = st_r.av[i];
                end else if (adr_i == 8'(`DCVC_WP_BASE + i * `DCVC_WP_STRIDE + `DCVC_WP_AM)) begin
                    rd_val = st_r.am[i];
                end else if (adr_i == 8'(`DCVC_WP_BASE + i * `DCVC_WP_STRIDE + `DCVC_WP_DV)) begin
                    rd_val = st_r.dv[i];
                end else if (adr_i == 8'(`DCVC_WP_BASE + i * `DCVC_WP_STRIDE + `DCVC_WP_DM)) begin
                    rd_val = st_r.dm[i];
                end else if (adr_i == 8'(`DCVC_WP_BASE + i * `DCVC_WP_STRIDE + `DCVC_WP_CV)) begin
                    rd_val = {23'h000000, st_r.cv[i]};
                end else if (adr_i == 8'(`DCVC_WP_BASE + i * `DCVC_WP_STRIDE + `DCVC_WP_CM)) begin
                    rd_val = {24'h000000, st_r.cm[i]};
                end
            end
        end
    end

    // next state
    always_comb begin
        st_nxt       = st_r;
        st_nxt.ack   = req;
        st_nxt.rdata = req ? rd_val : st_r.rdata;

        // synchronisers
        st_nxt.rq_s1   = st_r.ctrl[`DCVC_CTRL_REQ];
        st_nxt.rq_s2   = st_r.rq_s1;
        st_nxt.erq_s1  = external_debug_request_i;
        st_nxt.erq_s2  = st_r.erq_s1;
        st_nxt.dack_s1 = ack_comb;
        st_nxt.dack_s2 = st_r.dack_s1;
        st_nxt.ext_q   = external_debug_inputs_i;

        // chain latch: address/control hit loads the data hit
        if (NUM_WP > 1 && addr_ctl_hit[NUM_WP-1]) begin
            st_nxt.chain = data_hit[NUM_WP-1];
        end

        // register writes
        if (wr) begin
            if (adr_i == `DCVC_ADR_CTRL) begin
                st_nxt.ctrl = (st_r.ctrl & ~wmask[5:0]) | (dat_i[5:0] & wmask[5:0]);
            end else if (adr_i == `DCVC_ADR_VCATCH) begin
                st_nxt.vcatch = (st_r.vcatch & ~wmask[7:0]) | (dat_i[7:0] & wmask[7:0]);
            end else begin
                for (int i = 0; i < NUM_WP; i++) begin
                    if (adr_i == 8'(`DCVC_WP_BASE + i * `DCVC_WP_STRIDE + `DCVC_WP_AV)) begin
                        st_nxt.av[i] = (st_r.av[i] & ~wmask) | (dat_i & wmask);
                    end else if (adr_i == 8'(`DCVC_WP_BASE + i * `DCVC_WP_STRIDE
                                             + `DCVC_WP_AM)) begin
                        st_nxt.am[i] = (st_r.am[i] & ~wmask) | (dat_i & wmask);
                    end else if (adr_i == 8'(`DCVC_WP_BASE + i * `DCVC_WP_STRIDE
                                             + `DCVC_WP_DV)) begin
                        st_nxt.dv[i] = (st_r.dv[i] & ~wmask) | (dat_i & wmask);
                    end else if (adr_i == 8'(`DCVC_WP_BASE + i * `DCVC_WP_STRIDE
                                             + `DCVC_WP_DM)) begin
                        st_nxt.dm[i] = (st_r.dm[i] & ~wmask) | (dat_i & wmask);
                    end else if (adr_i == 8'(`DCVC_WP_BASE + i * `DCVC_WP_STRIDE
                                             + `DCVC_WP_CV)) begin
                        st_nxt.cv[i] = (st_r.cv[i] & ~wmask[8:0]) | (dat_i[8:0] & wmask[8:0]);
                        if (i == NUM_WP - 1) begin
                            st_nxt.chain = 1'b0;
                        end
                    end else if (adr_i == 8'(`DCVC_WP_BASE + i * `DCVC_WP_STRIDE
                                             + `DCVC_WP_CM)) begin
                        st_nxt.cm[i] = (st_r.cm[i] & ~wmask[7:0]) | (dat_i[7:0] & wmask[7:0]);
                    end
                end
            end
        end

        // single-step sequencer
        case (st_r.step)
            STEP_IDLE: begin
                if (core_debug_acknowledge_i == 1'b0 && st_r.dack_s1 == 1'b1
                    && st_r.ctrl[`DCVC_CTRL_STEP]) begin
                    st_nxt.step = STEP_FIRST;
                end
            end
            STEP_FIRST: begin
                if (core_debug_acknowledge_i) begin
                    st_nxt.step = STEP_IDLE;
                end else if (fetch_valid_i) begin
                    st_nxt.step = STEP_SECOND;
                end
            end
            STEP_SECOND: begin
                if (core_debug_acknowledge_i) begin
                    st_nxt.step = STEP_IDLE;
                end
            end
            default: begin
                st_nxt.step = STEP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r        <= '0;
            st_r.ctrl   <= `DCVC_CTRL_RESET;
            st_r.vcatch <= `DCVC_VC_RESET;
            st_r.step   <= STEP_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign ack_o = st_r.ack;
    assign dat_o = st_r.rdata;
endmodule // dcvc_top
`default_nettype wire

//--- hw/dcvc_cfg.svh
// Purpose: offsets, field positions, reset values for debug control block
// Assumes: 32-bit wishbone word registers, byte addresses
// Notes:   watchpoint unit n sits at DCVC_WP_BASE + n * DCVC_WP_STRIDE
`ifndef DCVC_CFG_SVH
`define DCVC_CFG_SVH

`define DCVC_ADR_CTRL     8'h00
`define DCVC_ADR_STATUS   8'h04
`define DCVC_ADR_VCATCH   8'h08
`define DCVC_WP_BASE      8'h20
`define DCVC_WP_STRIDE    8'h20
`define DCVC_WP_AV        8'h00
`define DCVC_WP_AM        8'h04
`define DCVC_WP_DV        8'h08
`define DCVC_WP_DM        8'h0C
`define DCVC_WP_CV        8'h10
`define DCVC_WP_CM        8'h14

`define DCVC_CTRL_ACK     0
`define DCVC_CTRL_REQ     1
`define DCVC_CTRL_INHIBIT 2
`define DCVC_CTRL_STEP    3
`define DCVC_CTRL_MONITOR 4
`define DCVC_CTRL_CMPOFF  5
`define DCVC_CTRL_RESET   6'h10
`define DCVC_VC_RESET     8'h00

`define DCVC_VC_PABORT    3
`define DCVC_VC_DABORT    4
`define DCVC_VC_RSVD      5
`define DCVC_CV_DATA      3
`define DCVC_CV_ENABLE    8

`endif

//--- hw/dcvc_pkg.sv
// Purpose: types of the debug control and vector catch block
// Assumes: nothing
// Notes:   state is one packed struct per module
package dcvc_pkg;
    typedef enum logic [1:0] {
        STEP_IDLE,
        STEP_FIRST,
        STEP_SECOND
    } dcvc_step_e;

    typedef struct packed {
        logic [5:0]        ctrl;
        logic [7:0]        vcatch;
        logic [1:0][31:0]  av;
        logic [1:0][31:0]  am;
        logic [1:0][31:0]  dv;
        logic [1:0][31:0]  dm;
        logic [1:0][8:0]   cv;
        logic [1:0][7:0]   cm;
        logic              ack;
        logic [31:0]       rdata;
        logic              rq_s1;
        logic              rq_s2;
        logic              erq_s1;
        logic              erq_s2;
        logic              dack_s1;
        logic              dack_s2;
        logic [1:0]        ext_q;
        logic              chain;
        dcvc_step_e        step;
    } dcvc_state_s;
endpackage

//--- hw/dcvc_watchpoint.sv
// Purpose: one watchpoint comparator unit
// Assumes: buses already selected by the caller
// Notes:   purely combinational, chain latch lives in the top
`timescale 1ns/10ps
`default_nettype none
`include "dcvc_cfg.svh"
module dcvc_watchpoint (
    input  wire logic [31:0] av_i,
    input  wire logic [31:0] am_i,
    input  wire logic [31:0] dv_i,
    input  wire logic [31:0] dm_i,
    input  wire logic [8:0]  cv_i,
    input  wire logic [7:0]  cm_i,
    input  wire logic [31:0] addr_i,
    input  wire logic [31:0] data_i,
    input  wire logic [9:0]  cbus_i,
    output logic             addr_hit_o,
    output logic             addr_ctl_hit_o,
    output logic             data_hit_o,
    output logic             trigger_o
);
    logic ctl_hit;

    // masked compares, mask bit set means don't care
    assign addr_hit_o     = &((av_i ~^ addr_i) | am_i);
    assign data_hit_o     = &((dv_i ~^ data_i) | dm_i);
    assign ctl_hit        = &((cv_i[7:0] ~^ cbus_i[7:0]) | cm_i);
    assign addr_ctl_hit_o = addr_hit_o & ctl_hit & cbus_i[9] & cbus_i[8];
    assign trigger_o      = addr_ctl_hit_o & data_hit_o & cv_i[`DCVC_CV_ENABLE];
endmodule // dcvc_watchpoint
`default_nettype wire

//--- tb/dcvc_properties.sv
// Purpose: port level assertions for dcvc_top
// Assumes: one clock domain, synchronous reset rst_i
// Notes:   bound into dcvc_top after the endmodule
`timescale 1ns/10ps
`default_nettype none
module dcvc_properties #(
    parameter int NUM_WP = 2
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [7:0]  adr_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic        debug_enable_pin_i,
    input wire logic        external_debug_request_i,
    input wire logic        debug_acknowledge_o,
    input wire logic        irq_i,
    input wire logic        fiq_i,
    input wire logic        irq_o,
    input wire logic        fiq_o,
    input wire logic        debug_request_o,
    input wire logic        core_debug_acknowledge_i,
    input wire logic        core_interrupt_enable_i,
    input wire logic        system_access_done_i,
    input wire logic        compressed_state_flag_i,
    input wire logic        instruction_breakpoint_o,
    input wire logic        data_watchpoint_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_irq_blocked: assert property (debug_enable_pin_i && core_debug_acknowledge_i
        |-> !irq_o && !fiq_o) else $error("interrupt passed in debug");
    a_irq_free: assert property (!debug_enable_pin_i
        |-> irq_o == irq_i && fiq_o == fiq_i) else $error("interrupt held while disabled");
    a_dis_quiet: assert property (!debug_enable_pin_i |-> !(debug_request_o
        || instruction_breakpoint_o || data_watchpoint_o || debug_acknowledge_o))
        else $error("debug output while disabled");
    a_ack_merged: assert property (debug_enable_pin_i && core_debug_acknowledge_i
        |-> debug_acknowledge_o) else $error("acknowledge lost");
    a_ext_request: assert property (debug_enable_pin_i && external_debug_request_i
        |-> debug_request_o) else $error("external request lost");
    a_bus_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("no bus answer");
    a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack too long");
    a_status_live: assert property (ack_o && $past(adr_i) == 8'h04 && !$past(we_i)
        |-> dat_o[31:2] == {27'h0, $past(compressed_state_flag_i),
        $past(system_access_done_i), $past(core_interrupt_enable_i)})
        else $error("status bits wrong");
endmodule // dcvc_properties
bind dcvc_top dcvc_properties #(.NUM_WP(NUM_WP)) u_props (.*);
`default_nettype wire

//--- tb/dcvc_core_model.sv
// Purpose: behavioural core facing the debug block
// Assumes: tb asks for single fetches and restarts
// Notes:   idle address bus shows inverse of last value
`timescale 1ns/10ps
`default_nettype none
module dcvc_core_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        go_i,
    input  wire logic        entry_i,
    input  wire logic [31:0] addr_i,
    input  wire logic        restart_i,
    input  wire logic        brk_i,
    input  wire logic        req_i,
    output logic             fetch_valid_o,
    output logic             entry_o,
    output logic [31:0]      ia_o,
    output logic [31:0]      fetched_instruction_bus_o,
    output logic             dbg_o,
    output logic             hit_o
);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fetch_valid_o <= 1'b0;
            entry_o       <= 1'b0;
            ia_o          <= 32'h0;
            fetched_instruction_bus_o       <= 32'h0;
            dbg_o         <= 1'b0;
            hit_o         <= 1'b0;
        end else begin
            fetch_valid_o <= go_i;
            entry_o       <= go_i & entry_i;
            ia_o          <= go_i ? addr_i : ~ia_o;
            fetched_instruction_bus_o       <= ~fetched_instruction_bus_o;
            if (restart_i)
                dbg_o <= 1'b0;
            else if (req_i || (fetch_valid_o && brk_i))
                dbg_o <= 1'b1;
            hit_o <= !restart_i && (hit_o || (fetch_valid_o && brk_i));
        end
    end
endmodule // dcvc_core_model
`default_nettype wire

//--- tb/tb.sv
// Purpose: self-checking bench for dcvc_top
// Assumes: wishbone classic master, core model partner
// Notes:   watchpoint units programmed late in the run
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, en = 1, erq = 0;
    logic        irq = 0, fiq = 0, cie = 0, sad = 0, csf = 0, dav = 0, dwr = 0;
    logic        go = 0, entry = 0, restart = 0, ack_o, dack_o, irq_o, fiq_o, dreq_o;
    logic        brk_o, dwp_o, fv, ef, cack, hit;
    logic [1:0]  ext = 0;
    logic [5:0]  cc = 0;
    logic [7:0]  adr = 0;
    logic [31:0] wdat = 0, fa = 0, da = 0, rd = 0, wd = 0, dat_o, ia, fetched_instruction_bus;
    int          fail_count = 0, n_checks = 0;
    dcvc_top #(.NUM_WP(2)) DUT (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
        .debug_enable_pin_i(en), .external_debug_request_i(erq),
        .external_debug_inputs_i(ext), .debug_acknowledge_o(dack_o), .irq_i(irq),
        .fiq_i(fiq), .irq_o(irq_o), .fiq_o(fiq_o), .debug_request_o(dreq_o),
        .core_debug_acknowledge_i(cack), .core_interrupt_enable_i(cie),
        .system_access_done_i(sad), .compressed_state_flag_i(csf), .fetch_valid_i(fv),
        .exception_entry_fetch_i(ef), .data_access_valid_i(dav), .data_write_i(dwr),
        .core_ctrl_i(cc), .instruction_address_bus_i(ia), .data_address_bus_i(da),
        .fetched_instruction_bus_i(fetched_instruction_bus), .read_data_i(rd), .write_data_i(wd),
        .instruction_breakpoint_o(brk_o), .data_watchpoint_o(dwp_o));
    dcvc_core_model u_core (
        .clk_i(clk_i), .rst_i(rst_i), .go_i(go), .entry_i(entry), .addr_i(fa),
        .restart_i(restart), .brk_i(brk_o), .req_i(dreq_o), .fetch_valid_o(fv),
        .entry_o(ef), .ia_o(ia), .fetched_instruction_bus_o(fetched_instruction_bus), .dbg_o(cack), .hit_o(hit));
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        da  <= $urandom;
        rd  <= $urandom;
        wd  <= $urandom;
        cc  <= 6'($urandom);
        ext <= 2'($urandom);
        dav <= 1'($urandom);
        dwr <= 1'($urandom);
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int i;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr   <= a;
        wdat  <= d;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_i);
            if (ack_o === 1'b1)
                break;
        end
        if (i == 20)
            check("wb ack", ack_o, 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
    endtask
    task automatic kick();
        @(posedge clk_i);
        restart <= 1'b1;
        @(posedge clk_i);
        restart <= 1'b0;
        ticks(4);
    endtask
    task automatic fetch(input logic [31:0] a, input logic ent);
        @(posedge clk_i);
        go    <= 1'b1;
        entry <= ent;
        fa    <= a;
        @(posedge clk_i);
        go <= 1'b0;
        ticks(3);
    endtask
    task automatic wp(input int u, input logic [31:0] av, am, dv, dm, cv, cm);
        logic [31:0] q;
        logic [7:0]  b;
        b = 8'h20 << u;
        wb(1'b1, b, av, q);
        wb(1'b1, b + 8'h04, am, q);
        wb(1'b1, b + 8'h08, dv, q);
        wb(1'b1, b + 8'h0C, dm, q);
        wb(1'b1, b + 8'h10, cv, q);
        wb(1'b1, b + 8'h14, cm, q);
    endtask
    initial begin
        logic [31:0] q;
        logic [7:0]  r;
        int          v;
        q = $urandom(32'h54E5075F);
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(0, 8'h00, 0, q);
        check("ctrl reset", q, 32'h10);
        wb(0, 8'h08, 0, q);
        check("vcatch reset", q, 32'h0);
        wb(0, 8'hFC, 0, q);
        check("unmapped", q, 32'h0);
        for (v = 0; v < 8; v++) begin
            irq <= 1'($urandom);
            fiq <= 1'($urandom);
            erq <= 1'($urandom);
            wb(1, 8'h00, v, q);
            @(negedge clk_i);
            check("dreq sync", dreq_o, erq);
            ticks(4);
            @(negedge clk_i);
            check("irq", irq_o, irq & ~(cack | v[0] | v[2]));
            check("fiq", fiq_o, fiq & ~(cack | v[0] | v[2]));
            check("dack", dack_o, cack | v[0]);
            check("dreq", dreq_o, erq | v[1]);
            wb(0, 8'h00, 0, q);
            check("ctrl read", q, v);
            erq <= 1'b0;
            wb(1, 8'h00, 0, q);
            kick();
        end
        repeat (4) begin
            cie <= 1'($urandom);
            sad <= 1'($urandom);
            csf <= 1'($urandom);
            erq <= 1'($urandom);
            ticks(4);
            wb(1, 8'h04, 32'hFFFFFFFF, q);
            wb(0, 8'h04, 0, q);
            check("status", q, {27'h0, csf, sad, cie, erq, cack});
            erq <= 1'b0;
            kick();
        end
        r = 8'($urandom) | 8'h38;
        wb(1, 8'h08, r, q);
        wb(0, 8'h08, 0, q);
        check("vcatch", q, r);
        for (v = 0; v < 24; v++) begin
            if (v % 8 == 0)
                wb(1, 8'h00, (v >= 16) ? 32'h10 : 32'h0, q);
            fetch(32'(v % 8 * 4), v < 8 || v >= 16);
            check("catch", hit, (v < 8 || v >= 16) && r[v % 8] && v % 8 != 5
                  && !(v >= 16 && (v % 8 == 3 || v % 8 == 4)));
            kick();
        end
        wb(1, 8'h00, 32'h02, q);
        ticks(4);
        check("halted", dack_o, 1'b1);
        wb(1, 8'h00, 32'h08, q);
        ticks(4);
        kick();
        fetch(32'h100, 1'b0);
        check("step first", hit, 1'b0);
        fetch(32'h104, 1'b0);
        check("step next", hit, 1'b1);
        wb(1, 8'h00, 32'h0, q);
        kick();
        wp(1, 32'h200, 32'h0, 32'h0, 32'hFFFFFFFF, 32'h100, 32'hFF);
        fetch(32'h200, 1'b0);
        check("wp addr", hit, 1'b1);
        kick();
        fetch(32'h204, 1'b0);
        check("wp miss", hit, 1'b0);
        wp(1, 32'h0, 32'hFFFFFFFE, 32'h0, 32'hFFFFFFFE, 32'h108, 32'hFF);
        repeat (8) begin
            @(negedge clk_i);
            check("wp data", dwp_o, dav & ~da[0] & ~(dwr ? wd[0] : rd[0]));
        end
        wp(1, 32'h0, 32'h1F, 32'h0, 32'hFFFFFFFF, 32'h0, 32'hFF);
        wp(0, 32'h0, 32'hFF, 32'h0, 32'hFFFFFFFF, 32'h100, 32'h7F);
        fetch(32'h40, 1'b0);
        check("range out", hit, 1'b1);
        kick();
        fetch(32'h10, 1'b0);
        check("range in", hit, 1'b0);
        wp(1, 32'h300, 32'h0, 32'h0, 32'hFFFFFFFF, 32'h0, 32'hFF);
        wp(0, 32'h40, 32'h0, 32'h0, 32'hFFFFFFFF, 32'h140, 32'hBF);
        fetch(32'h40, 1'b0);
        check("chain off", hit, 1'b0);
        fetch(32'h300, 1'b0);
        fetch(32'h40, 1'b0);
        check("chain on", hit, 1'b1);
        kick();
        en  <= 1'b0;
        irq <= 1'b1;
        fiq <= 1'b1;
        erq <= 1'b1;
        wb(1, 8'h00, 32'h07, q);
        ticks(4);
        @(negedge clk_i);
        check("dis irq", {irq_o, fiq_o}, 2'b11);
        check("dis req", {dreq_o, dack_o, brk_o, dwp_o}, 4'b0000);
        give_verdict();
    end
endmodule // tb
`default_nettype wire
